//--- inc/cif_pkg.sv
/*
 * cif_pkg: encodings, register numbers, field positions and timing
 * constants for the custom instruction and feature register block.
 * assumes: a 64-bit core with 32-bit instruction words and 12-bit
 * register numbers on the system opcode.
 */
package cif_pkg;
    // instruction fields
    localparam logic [6:0]  CIF_OPC_SYSTEM    = 7'h73;
    localparam logic [2:0]  CIF_F3_CUSTOM     = 3'h0;
    localparam logic [31:0] CIF_ENC_DISCARD   = 32'hfc200073;
    localparam logic [31:0] CIF_ENC_HALT      = 32'h30500073;
    localparam logic [31:0] CIF_ENC_PAUSE     = 32'h0100000f;
    localparam logic [31:0] CIF_ENC_WBINV     = 32'hfc000073;
    localparam logic [31:0] CIF_RS1_MASK      = 32'h000f8000;
    localparam int          CIF_RS1_HI        = 19;
    localparam int          CIF_RS1_LO        = 15;
    localparam logic [4:0]  CIF_REG_ZERO      = 5'h00;
    // privilege
    localparam logic [1:0]  CIF_PRIV_MACHINE  = 2'h3;
    // register numbers
    localparam logic [11:0] CIF_CSR_BPC       = 12'h7c0;
    localparam logic [11:0] CIF_CSR_FOC       = 12'h7c1;
    // feature-off field positions
    localparam int          CIF_FOC_ICG       = 1;
    localparam int          CIF_FOC_PCG       = 2;
    localparam int          CIF_FOC_SPEC      = 3;
    localparam int          CIF_FOC_CORRUPT   = 9;
    localparam int          CIF_FOC_SFB       = 16;
    localparam int          CIF_FOC_PREF      = 17;
    localparam logic [63:0] CIF_FOC_IMPL      = 64'h0000_0000_0003_020e;
    localparam logic        CIF_BPC_RESET     = 1'h0;
    // pause stall limit
    localparam int          CIF_PAUSE_CYCLES  = 32;
    localparam logic [5:0]  CIF_PAUSE_COUNT   = 6'(CIF_PAUSE_CYCLES);

    // maintenance operation kinds
    typedef enum logic [1:0] {
        CIF_MAINT_WBINV   = 2'h1,
        CIF_MAINT_DISCARD = 2'h2
    } cif_maint_type;

    // request to the data cache
    typedef struct packed {
        logic          valid;
        cif_maint_type kind;
        logic          whole;
        logic [63:0]   vaddr;
    } cif_cache_req_type;

    // address permission answer from translation and protection
    typedef struct packed {
        logic valid;
        logic writable;
        logic cacheable;
        logic page_fault;
    } cif_perm_type;
endpackage : cif_pkg

//--- rtl/cif_custom_instr.sv
/*
 * cif_custom_instr: decodes and executes custom cache maintenance,
 * halt-for-power-down and pause hint, and holds the branch prediction
 * control and feature-off registers.
 * assumes: the pipeline offers one instruction at a time and holds it
 * until done; translation answers permission checks for rs1 addresses;
 * the data cache acknowledges each maintenance request with a pulse.
 */
module cif_custom_instr
    import cif_pkg::*;
(
    // clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       reset_n_in,
    // instruction issue from the pipeline
    input  wire logic                       instr_valid_in,
    input  wire logic [31:0]                instr_in,
    input  wire logic [63:0]                rs1_value_in,
    input  wire logic [1:0]                 priv_in,
    // register access from the pipeline
    input  wire logic                       csr_write_in,
    input  wire logic [11:0]                csr_addr_in,
    input  wire logic [63:0]                csr_wdata_in,
    // permission answer for the rs1 address
    input  wire cif_pkg::cif_perm_type      perm_in,
    // data cache side
    input  wire logic                       cache_done_in,
    input  wire logic                       evict_in,
    // power-down handshake from the core complex
    input  wire logic                       powerdown_ready_in,
    // answers to the pipeline
    output logic                            instr_done_out,
    output logic                            illegal_out,
    output logic                            store_access_fault_out,
    output logic                            store_page_fault_out,
    output logic                            stall_out,
    output logic                            retire_block_out,
    output logic [63:0]                     csr_rdata_out,
    // data cache request
    output cif_pkg::cif_cache_req_type      cache_req_out,
    // branch predictor controls
    output logic                            static_taken_out,
    output logic                            btb_clear_out,
    // feature controls
    output logic [63:0]                     feature_off_out,
    // request to begin power-down and safe-to-remove indication
    output logic                            powerdown_req_out,
    output logic                            power_safe_out
);
    // sequencer states
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_CHECK  = 6'b000010,
        ST_CACHE  = 6'b000100,
        ST_PAUSE  = 6'b001000,
        ST_HALT   = 6'b010000,
        ST_DONE   = 6'b100000
    } cif_state_type;

    // match an instruction against a fixed encoding, rs1 field ignored
    function automatic logic cif_match_rs1(input logic [31:0] word,
                                           input logic [31:0] enc);
        cif_match_rs1 = (word & ~CIF_RS1_MASK) == enc;
    endfunction : cif_match_rs1

    cif_state_type     state_q, state_d;      // sequencer state
    logic [5:0]        pause_q, pause_d;      // pause cycles left
    cif_maint_type     kind_q, kind_d;        // pending maintenance kind
    logic              whole_q, whole_d;      // whole-cache operation
    logic [63:0]       vaddr_q, vaddr_d;      // latched rs1 address
    logic              bdp_q;                 // direction prediction bit
    logic [63:0]       foc_q;                 // feature-off bits
    logic              halted_q;              // halt retired
    logic              done_q, ill_q, saf_q, spf_q; // answer flags
    logic              btbc_q;                // target buffer clear pulse
    logic              preq_q, psafe_q;       // power-down outputs
    cif_cache_req_type creq_q;                // cache request register
    logic [63:0]       rdata_q;               // read data register

    // decode of the offered word
    wire logic       is_custom = instr_in[6:0] == CIF_OPC_SYSTEM &&
                                 instr_in[14:12] == CIF_F3_CUSTOM;
    wire logic       is_wbinv  = is_custom &&
                                 cif_match_rs1(instr_in, CIF_ENC_WBINV);
    wire logic       is_disc   = is_custom &&
                                 cif_match_rs1(instr_in, CIF_ENC_DISCARD);
    wire logic       is_halt   = instr_in == CIF_ENC_HALT;
    wire logic       is_pause  = instr_in == CIF_ENC_PAUSE;
    wire logic       is_mach   = priv_in == CIF_PRIV_MACHINE;
    wire logic [4:0] rs1_idx   = instr_in[CIF_RS1_HI:CIF_RS1_LO];
    wire logic       take      = instr_valid_in && !halted_q &&
                                 state_q == ST_IDLE;
    wire logic       csr_bpc   = csr_write_in && csr_addr_in == CIF_CSR_BPC;
    wire logic       csr_foc   = csr_write_in && csr_addr_in == CIF_CSR_FOC;
    wire logic       fault     = perm_in.valid && !perm_in.writable;
    wire logic       skip      = perm_in.valid && perm_in.writable &&
                                 !perm_in.cacheable;

    // next state of the sequencer
    always_comb begin
        state_d = state_q;
        pause_d = pause_q;
        kind_d  = kind_q;
        whole_d = whole_q;
        vaddr_d = vaddr_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take && (is_wbinv || is_disc) && is_mach) begin
                    kind_d  = is_wbinv ? CIF_MAINT_WBINV : CIF_MAINT_DISCARD;
                    whole_d = rs1_idx == CIF_REG_ZERO;
                    vaddr_d = rs1_value_in;
                    state_d = whole_d ? ST_CACHE : ST_CHECK;
                end else if (take && is_halt && is_mach) begin
                    state_d = ST_HALT;
                end else if (take && is_pause) begin
                    pause_d = CIF_PAUSE_COUNT;
                    state_d = ST_PAUSE;
                end else if (take) begin
                    state_d = ST_DONE;
                end
            end
            ST_CHECK: begin
                // line operations wait for the permission answer
                if (fault || skip) begin
                    state_d = ST_DONE;
                end else if (perm_in.valid) begin
                    state_d = ST_CACHE;
                end
            end
            ST_CACHE: begin
                if (cache_done_in) begin
                    state_d = ST_DONE;
                end
            end
            ST_PAUSE: begin
                pause_d = pause_q - 6'h01;
                if (evict_in || pause_q == 6'h01) begin
                    state_d = ST_DONE;
                end
            end
            ST_HALT: begin
                state_d = ST_HALT;
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_q <= ST_IDLE;
            pause_q <= 6'h00;
            kind_q  <= CIF_MAINT_WBINV;
            whole_q <= 1'b0;
            vaddr_q <= 64'h0;
        end else begin
            state_q <= state_d;
            pause_q <= pause_d;
            kind_q  <= kind_d;
            whole_q <= whole_d;
            vaddr_q <= vaddr_d;
        end
    end

    // answers to the pipeline, one-cycle pulses except halt hold
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            done_q   <= 1'b0;
            ill_q    <= 1'b0;
            saf_q    <= 1'b0;
            spf_q    <= 1'b0;
            halted_q <= 1'b0;
        end else begin
            done_q <= state_d == ST_DONE ||
                      (state_q == ST_IDLE && state_d == ST_HALT);
            ill_q  <= take && !is_mach &&
                      (is_wbinv || is_disc || is_halt);
            saf_q  <= state_q == ST_CHECK && fault &&
                      !perm_in.page_fault;
            spf_q  <= state_q == ST_CHECK && fault &&
                      perm_in.page_fault;
            halted_q <= halted_q || state_d == ST_HALT;
        end
    end

    // cache request issued on entry to the cache state
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            creq_q <= '0;
        end else begin
            creq_q.valid <= state_q != ST_CACHE && state_d == ST_CACHE;
            creq_q.kind  <= kind_d;
            creq_q.whole <= whole_d;
            creq_q.vaddr <= vaddr_d;
        end
    end

    // power-down: request after halt, safe once complex agrees
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            preq_q  <= 1'b0;
            psafe_q <= 1'b0;
        end else begin
            preq_q  <= halted_q;
            psafe_q <= psafe_q || (preq_q && powerdown_ready_in);
        end
    end

    // prediction control and feature-off registers
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            bdp_q  <= CIF_BPC_RESET;
            btbc_q <= 1'b0;
            foc_q  <= CIF_FOC_IMPL;
        end else begin
            btbc_q <= csr_bpc;
            if (csr_bpc) begin
                bdp_q <= csr_wdata_in[0];
            end
            if (csr_foc) begin
                foc_q <= csr_wdata_in & CIF_FOC_IMPL;
            end
        end
    end

    // read data, captured from the addressed register
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_q <= 64'h0;
        end else if (csr_addr_in == CIF_CSR_BPC) begin
            rdata_q <= {63'h0, bdp_q};
        end else if (csr_addr_in == CIF_CSR_FOC) begin
            rdata_q <= foc_q;
        end else begin
            rdata_q <= 64'h0;
        end
    end

    // outputs straight from flip-flops, except stall decoded from the state register
    assign instr_done_out         = done_q;
    assign illegal_out            = ill_q;
    assign store_access_fault_out = saf_q;
    assign store_page_fault_out   = spf_q;
    assign stall_out              = state_q != ST_IDLE;
    assign retire_block_out       = halted_q;
    assign csr_rdata_out          = rdata_q;
    assign cache_req_out          = creq_q;
    assign static_taken_out       = bdp_q;
    assign btb_clear_out          = btbc_q;
    assign feature_off_out        = foc_q;
    assign powerdown_req_out      = preq_q;
    assign power_safe_out         = psafe_q;
endmodule : cif_custom_instr

//--- bench/cif_props.sv
/* cif_props: port checker for cif_custom_instr.
   assumes: bound to the design top; one clock, sync low reset. */
module cif_props
    import cif_pkg::*;
(
    // watched ports
    input wire logic              clk_in,
    input wire logic              reset_n_in,
    input wire logic              instr_valid_in,
    input wire logic [31:0]       instr_in,
    input wire logic [1:0]        priv_in,
    input wire logic              csr_write_in,
    input wire logic [11:0]       csr_addr_in,
    input wire logic [63:0]       csr_wdata_in,
    input wire logic              instr_done_out,
    input wire logic              illegal_out,
    input wire logic              stall_out,
    input wire logic              retire_block_out,
    input wire cif_cache_req_type cache_req_out,
    input wire logic              static_taken_out,
    input wire logic              btb_clear_out,
    input wire logic [63:0]       feature_off_out,
    input wire logic              powerdown_req_out,
    input wire logic              power_safe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // an instruction is taken while idle
    wire logic take = instr_valid_in && !stall_out && !instr_done_out
        && !retire_block_out;
    wire logic m_mode = priv_in == CIF_PRIV_MACHINE;
    wire logic bpc_wr = csr_write_in && csr_addr_in == CIF_CSR_BPC;
    wire logic foc_wr = csr_write_in && csr_addr_in == CIF_CSR_FOC;
    // exact encoding taken
    sequence s_take(logic [31:0] enc);
        take && instr_in == enc;
    endsequence
    a_wbinv_whole: assert property (s_take(CIF_ENC_WBINV) ##0 m_mode
        |=> cache_req_out.valid && cache_req_out.whole
        && cache_req_out.kind == CIF_MAINT_WBINV)
        else $error("whole write-back request missing");
    a_discard_whole: assert property (s_take(CIF_ENC_DISCARD) ##0 m_mode
        |=> cache_req_out.valid && cache_req_out.whole
        && cache_req_out.kind == CIF_MAINT_DISCARD)
        else $error("whole discard request missing");
    a_halt_illegal: assert property (s_take(CIF_ENC_HALT) ##0 !m_mode
        |=> illegal_out && instr_done_out)
        else $error("halt outside machine mode not refused");
    a_pause_bound: assert property (s_take(CIF_ENC_PAUSE)
        |-> ##[1:34] instr_done_out)
        else $error("pause stalled too long");
    a_retire_sticky: assert property (retire_block_out
        |=> retire_block_out && !instr_done_out)
        else $error("retired after halt");
    a_safe_after_req: assert property (power_safe_out
        |-> powerdown_req_out ##1 power_safe_out)
        else $error("power safe without request or dropped");
    a_btb_on_write: assert property (bpc_wr
        |=> btb_clear_out && static_taken_out == $past(csr_wdata_in[0]))
        else $error("direction write effect wrong");
    a_btb_only_write: assert property (btb_clear_out
        |-> $past(bpc_wr))
        else $error("target buffer cleared without write");
    a_foc_write: assert property (foc_wr
        |=> feature_off_out == ($past(csr_wdata_in) & CIF_FOC_IMPL))
        else $error("feature register write wrong");
    a_foc_reserved: assert property (
        (feature_off_out & ~CIF_FOC_IMPL) == 64'h0)
        else $error("reserved feature bit set");
endmodule : cif_props

//--- bench/cif_far_side.sv
/* cif_far_side: data cache, translation and power model.
   assumes: requests and stall come from cif_custom_instr. */
module cif_far_side
    import cif_pkg::*;
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    // from the block
    input  wire cif_cache_req_type cache_req_in,
    input  wire logic              stall_in,
    input  wire logic              powerdown_req_in,
    // answer settings from the bench
    input  wire logic              writable_in,
    input  wire logic              cacheable_in,
    input  wire logic              page_fault_in,
    input  wire logic [3:0]        lat_in,
    // answers to the block
    output cif_perm_type           perm_out,
    output logic                   cache_done_out,
    output logic                   powerdown_ready_out
);
    logic [3:0] cnt_q;   // cycles left in maintenance
    logic       busy_q;  // maintenance running
    logic       asked_q; // permission already answered
    logic [1:0] pd_q;    // power-down ready delay
    // cache, permission and power answers
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            {cnt_q, busy_q, asked_q, pd_q} <= '0;
            perm_out <= '0;
            cache_done_out <= 1'b0;
        end else begin
            cache_done_out <= 1'b0;
            perm_out <= '0;
            pd_q <= {pd_q[0], powerdown_req_in};
            if (cache_req_in.valid) begin
                busy_q <= 1'b1;
                cnt_q <= lat_in;
            end else if (busy_q && cnt_q == 4'h0) begin
                busy_q <= 1'b0;
                cache_done_out <= 1'b1;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
            // one permission answer per stall stretch
            if (!stall_in) begin
                asked_q <= 1'b0;
            end else if (!asked_q) begin
                asked_q <= 1'b1;
                perm_out <= {1'b1, writable_in, cacheable_in, page_fault_in};
            end
        end
    end
    assign powerdown_ready_out = pd_q[1];
endmodule : cif_far_side

//--- bench/tb_top.sv
/* tb_top: self-checking bench for cif_custom_instr.
   assumes: far side in cif_far_side, checker in cif_props. */
module tb_top
    import cif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in, reset_n_in, instr_valid_in, csr_write_in, cache_done_in;
    logic evict_in, powerdown_ready_in, instr_done_out, illegal_out;
    logic store_access_fault_out, store_page_fault_out, stall_out;
    logic retire_block_out, static_taken_out, btb_clear_out;
    logic powerdown_req_out, power_safe_out, pw, pc, ppf;
    logic s_req, s_whole, s_ill, s_saf, s_spf, s_done, s_btb;
    logic [31:0] instr_in, e;
    logic [63:0] rs1_value_in, csr_wdata_in, csr_rdata_out, d;
    logic [63:0] feature_off_out, s_addr;
    logic [11:0] csr_addr_in;
    logic [1:0]  priv_in, s_kind;
    logic [3:0]  lat;
    cif_perm_type      perm_in;
    cif_cache_req_type cache_req_out;
    int error_cnt = 0;
    int n_compared = 0;
    int s_cyc, k, i;
    cif_custom_instr dut (.clk_in, .reset_n_in, .instr_valid_in, .instr_in,
        .rs1_value_in, .priv_in, .csr_write_in, .csr_addr_in, .csr_wdata_in,
        .perm_in, .cache_done_in, .evict_in, .powerdown_ready_in,
        .instr_done_out, .illegal_out, .store_access_fault_out,
        .store_page_fault_out, .stall_out, .retire_block_out, .csr_rdata_out,
        .cache_req_out, .static_taken_out, .btb_clear_out, .feature_off_out,
        .powerdown_req_out, .power_safe_out);
    cif_far_side far (.clk_in, .reset_n_in, .cache_req_in(cache_req_out),
        .stall_in(stall_out), .powerdown_req_in(powerdown_req_out),
        .writable_in(pw), .cacheable_in(pc), .page_fault_in(ppf),
        .lat_in(lat), .perm_out(perm_in), .cache_done_out(cache_done_in),
        .powerdown_ready_out(powerdown_ready_in));
    // clock
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // compare and count
    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic complete_run();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // register write, btb pulse seen at the next negedge
    task automatic wcsr(logic [11:0] a, logic [63:0] v);
        {csr_addr_in, csr_wdata_in, csr_write_in} = {a, v, 1'b1};
        @(negedge clk_in);
        csr_write_in = 1'b0;
        s_btb = btb_clear_out;
        @(negedge clk_in);
    endtask : wcsr
    // offer one instruction, gather its answers, evict at cycle ev
    task automatic issue(logic [31:0] ins, logic [63:0] rs, logic [1:0] pv,
                         int ev);
        {s_req, s_ill, s_saf, s_spf, s_done} = '0;
        {instr_in, rs1_value_in, priv_in} = {ins, rs, pv};
        instr_valid_in = 1'b1;
        for (s_cyc = 1; s_cyc < 60 && !s_done; s_cyc++) begin
            @(negedge clk_in);
            evict_in = (s_cyc == ev);
            s_ill = s_ill | illegal_out;
            s_saf = s_saf | store_access_fault_out;
            s_spf = s_spf | store_page_fault_out;
            if (cache_req_out.valid === 1'b1) begin
                {s_req, s_kind, s_whole, s_addr} = cache_req_out;
            end
            s_done = instr_done_out;
        end
        {instr_valid_in, evict_in} = 2'b00;
        @(negedge clk_in);
    endtask : issue
    initial begin
        void'($urandom(78));
        {reset_n_in, instr_valid_in, csr_write_in, evict_in} = '0;
        {instr_in, rs1_value_in, priv_in, csr_addr_in, csr_wdata_in} = '0;
        {pw, pc, ppf, lat} = '0;
        repeat (4) @(negedge clk_in);
        reset_n_in = 1'b1;
        chk("foc_reset", feature_off_out, 64'h3020e);
        chk("bdp_reset", static_taken_out, 64'h0);
        d = {$urandom, $urandom};
        wcsr(12'h7c1, d);
        chk("foc_wr", feature_off_out, d & 64'h3020e);
        chk("foc_rd", csr_rdata_out, d & 64'h3020e);
        wcsr(12'h7c1, 64'h0);
        chk("foc_clr", csr_rdata_out, 64'h0);
        for (k = 0; k < 3; k++) begin
            wcsr(12'h7c0, 64'(k & 1));
            chk("btb_clr", s_btb, 64'h1);
            chk("bdp", static_taken_out, 64'(k & 1));
        end
        for (k = 0; k < 2; k++) begin
            e = k ? CIF_ENC_DISCARD : CIF_ENC_WBINV;
            lat = 4'($urandom_range(6, 0));
            issue(e, 64'h0, 2'h3, 0);
            chk("whole", {s_req, s_kind, s_whole},
                {1'b1, 2'(k + 1), 1'b1});
            {pw, pc, ppf} = 3'b110;
            d = {$urandom, $urandom};
            issue(e | 32'h28000, d, 2'h3, 0);
            chk("line", {s_req, s_kind, s_whole},
                {1'b1, 2'(k + 1), 1'b0});
            chk("vaddr", s_addr, d);
            {pw, pc, ppf} = 3'b000;
            issue(e | 32'h28000, d, 2'h3, 0);
            chk("access", {s_saf, s_spf, s_req}, 64'h4);
            {pw, pc, ppf} = 3'b001;
            issue(e | 32'h28000, d, 2'h3, 0);
            chk("page", {s_saf, s_spf, s_req}, 64'h2);
            {pw, pc, ppf} = 3'b100;
            issue(e | 32'h28000, d, 2'h3, 0);
            chk("uncached", {s_done, s_saf, s_spf, s_req}, 64'h8);
            issue(e, 64'h0, 2'h1, 0);
            chk("priv", {s_ill, s_req}, 64'h2);
        end
        issue(CIF_ENC_WBINV | 32'h1000, 64'h0, 2'h3, 0);
        chk("funct3", {s_done, s_req, s_ill}, 64'h4);
        issue(CIF_ENC_PAUSE, 64'h0, 2'h3, 0);
        chk("pause_len", s_cyc >= 32 && s_cyc <= 40, 64'h1);
        chk("pause_nop", {s_req, s_ill}, 64'h0);
        issue(CIF_ENC_PAUSE, 64'h0, 2'h3, 5);
        chk("pause_ev", s_cyc < 12, 64'h1);
        issue(CIF_ENC_HALT, 64'h0, 2'h0, 0);
        chk("halt_priv", {s_ill, retire_block_out}, 64'h2);
        issue(CIF_ENC_HALT, 64'h0, 2'h3, 0);
        for (i = 0; i < 20 && power_safe_out !== 1'b1; i++) begin
            @(negedge clk_in);
        end
        chk("halted", {retire_block_out, powerdown_req_out, power_safe_out},
            64'h7);
        issue(CIF_ENC_PAUSE, 64'h0, 2'h3, 0);
        chk("after_halt", s_done, 64'h0);
        complete_run();
    end
    // hang guard
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule : tb_top
bind cif_custom_instr cif_props u_props (.clk_in, .reset_n_in,
    .instr_valid_in, .instr_in, .priv_in, .csr_write_in, .csr_addr_in,
    .csr_wdata_in, .instr_done_out, .illegal_out, .stall_out,
    .retire_block_out, .cache_req_out, .static_taken_out, .btb_clear_out,
    .feature_off_out, .powerdown_req_out, .power_safe_out);
